// ### bench/rxc_chk.sv
// Checker for the regulator extra control and power configuration pair
// Assumes binding onto rxc_top; T follows the top's timeout parameter
`timescale 1ns/1ps
module rxc_chk #(
  parameter logic [27:0] T = 28'h14
) (
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire rxc_pkg::rxc_req_t      req,
  input wire logic [7:0]             rdata,
  input wire logic                   full_shutdown_state,
  input wire rxc_pkg::rxc_reg_stat_t reg1_stat,
  input wire rxc_pkg::rxc_reg_stat_t reg2_stat,
  input wire logic                   reg1_discharge,
  input wire logic                   reg1_scaling,
  input wire logic                   reg2_discharge,
  input wire logic                   reg2_scaling,
  input wire logic                   pin_pull_up,
  input wire logic                   pin_pull_down,
  input wire logic                   boot_shutdown
);
  logic [27:0] cnt;
  logic        conf;
  wire         conf_wr = req.wr && req.addr == 8'h1d && req.wdata[0];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= '0;
      conf <= 1'b0;
    end else begin
      cnt  <= (cnt > T + 28'h3) ? cnt : cnt + 28'h1;
      conf <= conf | conf_wr;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rsv_a; req.rd && req.addr == 8'h1c |=> (rdata & 8'hcc) == 8'h00; endproperty
  a_rsv_a: assert property (p_rsv_a) else $error("0x1c spare bits set");
  property p_rsv_b; req.rd && req.addr == 8'h1d |=> (rdata & 8'h7e) == 8'h00; endproperty
  a_rsv_b: assert property (p_rsv_b) else $error("0x1d spare bits set");
  property p_dis2; full_shutdown_state |=> reg2_discharge; endproperty
  a_dis2: assert property (p_dis2) else $error("reg2 not discharged");
  property p_dis1; full_shutdown_state |=> reg1_discharge; endproperty
  a_dis1: assert property (p_dis1) else $error("reg1 not discharged");
  property p_sc2; reg2_stat.turn_on |=> reg2_scaling; endproperty
  a_sc2: assert property (p_sc2) else $error("reg2 not scaled");
  property p_sc1; !reg1_stat.turn_on && !reg1_stat.steady_on |=> !reg1_scaling; endproperty
  a_sc1: assert property (p_sc1) else $error("reg1 scaled while off");
  property p_pull; req.wr && req.addr == 8'h1d && !req.wdata[7] ##1 !req.wr
    |=> !pin_pull_up && !pin_pull_down; endproperty
  a_pull: assert property (p_pull) else $error("pull active while disabled");
  property p_late; cnt == T + 28'h2 && !(conf || conf_wr) |-> boot_shutdown; endproperty
  a_late: assert property (p_late) else $error("no shutdown after timeout");
  property p_keep; conf_wr && !boot_shutdown |=> !boot_shutdown [*8]; endproperty
  a_keep: assert property (p_keep) else $error("shutdown after confirm");
  c_shut: cover property (boot_shutdown);
  c_conf: cover property (conf_wr);
  c_dis: cover property (reg1_discharge && !full_shutdown_state);
endmodule
bind rxc_top rxc_chk #(.T(BOOT_TIMEOUT_CYCLES)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
  .full_shutdown_state(full_shutdown_state), .reg1_stat(reg1_stat), .reg2_stat(reg2_stat),
  .reg1_discharge(reg1_discharge), .reg1_scaling(reg1_scaling),
  .reg2_discharge(reg2_discharge), .reg2_scaling(reg2_scaling),
  .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .boot_shutdown(boot_shutdown));

// ### bench/rxc_host.sv
// Host model: issues one-cycle decoded register accesses
// Assumes rdata is valid one cycle after the read edge
`timescale 1ns/1ps
module rxc_host (
  input  wire logic         sys_clk,
  input  wire logic [7:0]   rdata,
  output rxc_pkg::rxc_req_t req
);
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1 q = rdata;
  endtask
endmodule

// ### bench/rxc_top_tb.sv
// Self-checking bench for rxc_top
// Assumes rxc_host makes the register accesses
`timescale 1ns/1ps
module rxc_top_tb;
  logic                   sys_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   fss = 1'b0;
  logic                   pu = 1'b1;
  rxc_pkg::rxc_reg_stat_t s1 = 3'b101;
  rxc_pkg::rxc_reg_stat_t s2 = 3'b101;
  rxc_pkg::rxc_req_t      req;
  logic [7:0]             rdata, q;
  logic                   d1, c1, d2, c2, pup, pdn, bsd;
  int                     errors = 0;
  int                     checks_done = 0;
  logic [23:0] rows[6] = '{24'h1cff33, 24'h1ccc00, 24'h1c2121, 24'h1eff00, 24'h1dfe81, 24'h1d0001};
  rxc_host u_h (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  rxc_top #(.BOOT_TIMEOUT_CYCLES(28'd20)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req),
    .rdata(rdata), .full_shutdown_state(fss), .reg1_stat(s1), .reg2_stat(s2),
    .pull_up_wanted(pu), .reg1_discharge(d1), .reg1_scaling(c1), .reg2_discharge(d2),
    .reg2_scaling(c2), .pin_pull_up(pup), .pin_pull_down(pdn), .boot_shutdown(bsd));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #80000;
    errors++;
    wrap_up();
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    wt(24);
    chk("shutdown", 8'h01, {7'h0, bsd});
    @(posedge sys_clk);
    nrst <= 1'b0;
    wt(2);
    chk("reset", 8'h00, {7'h0, bsd});
    @(posedge sys_clk);
    nrst <= 1'b1;
    u_h.acc(1'b0, 8'h1d, 8'h00, q);
    chk("pwr reset", 8'h00, q);
    u_h.acc(1'b1, 8'h1d, 8'h01, q);
    wt(30);
    chk("confirmed", 8'h00, {7'h0, bsd});
    $display("test boot done");
    foreach (rows[i]) begin
      u_h.acc(1'b1, rows[i][23:16], rows[i][15:8], q);
      u_h.acc(1'b0, rows[i][23:16], 8'h00, q);
      chk("readback", rows[i][7:0], q);
    end
    $display("test table done");
    u_h.acc(1'b1, 8'h1c, 8'h00, q);
    wt(2);
    chk("scale off", 8'h00, {6'h0, c2, c1});
    u_h.acc(1'b1, 8'h1c, 8'h11, q);
    wt(2);
    chk("scale on", 8'h03, {6'h0, c2, c1});
    u_h.acc(1'b1, 8'h1c, 8'h01, q);
    @(posedge sys_clk);
    s1 <= 3'b100;
    s2 <= 3'b110;
    wt(2);
    chk("scale turn-on", 8'h02, {6'h0, c2, c1});
    @(posedge sys_clk);
    s1 <= 3'b101;
    s2 <= 3'b101;
    u_h.acc(1'b1, 8'h1c, 8'h02, q);
    @(posedge sys_clk);
    s1.en <= 1'b0;
    s2.en <= 1'b0;
    wt(3);
    chk("dis sel", 8'h01, {6'h0, d2, d1});
    @(posedge sys_clk);
    fss <= 1'b1;
    wt(2);
    chk("dis shut", 8'h03, {6'h0, d2, d1});
    @(posedge sys_clk);
    fss   <= 1'b0;
    s1.en <= 1'b1;
    s2.en <= 1'b1;
    u_h.acc(1'b1, 8'h1c, 8'h20, q);
    @(posedge sys_clk);
    s1.en <= 1'b0;
    s2.en <= 1'b0;
    wt(3);
    chk("dis sel 2", 8'h02, {6'h0, d2, d1});
    $display("test regulators done");
    u_h.acc(1'b1, 8'h1d, 8'h81, q);
    wt(2);
    chk("pull up", 8'h02, {6'h0, pup, pdn});
    @(posedge sys_clk);
    pu <= 1'b0;
    wt(2);
    chk("pull down", 8'h01, {6'h0, pup, pdn});
    u_h.acc(1'b1, 8'h1d, 8'h01, q);
    wt(2);
    chk("pull off", 8'h00, {6'h0, pup, pdn});
    $display("test pulls done");
    wrap_up();
  end
endmodule

// ### logic/rxc_regulator_ctrl.sv
// One step-down regulator's discharge and transistor scaling control
// Assumes enable and phase flags synchronous to sys_clk
`timescale 1ns/1ps
module rxc_regulator_ctrl (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // Settings
  input  wire logic                   discharge_select,
  input  wire logic                   force_scaling,
  input  wire logic                   full_shutdown_state,
  // Regulator state
  input  wire rxc_pkg::rxc_reg_stat_t stat,
  // Controls
  output logic                        ctrl_discharge,
  output logic                        ctrl_scaling
);

  typedef struct packed {
    logic                   en_d;
    rxc_pkg::rxc_reg_ctrl_t ctrl;
  } rxc_rc_state_t;

  rxc_rc_state_t state;
  rxc_rc_state_t next_state;

  always_comb begin
    next_state                    = state;
    next_state.en_d               = stat.en;
    // Discharge held while disabled once enable has fallen
    next_state.ctrl.discharge     = full_shutdown_state ||
                                    (discharge_select && !stat.en &&
                                     (state.ctrl.discharge || state.en_d));
    next_state.ctrl.force_scaling = stat.turn_on || (force_scaling && stat.steady_on);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ctrl_discharge = state.ctrl.discharge;
  assign ctrl_scaling   = state.ctrl.force_scaling;

endmodule

// ### logic/rxc_top.sv
// Regulator extra control and power configuration registers
// Assumes an I2C target delivers one-cycle decoded accesses on sys_clk
//
// Summary of operation
// - Regulator 2 discharge on shutdown, optionally disable
// - Regulator 1 discharge on shutdown, optionally disable
// - Regulator 2 scaling at turn-on, optionally steady
// - Pin-pull enable gates automatic pin pulls
// - Unconfirmed after five seconds forces shutdown
// - Boot confirm sticky; timeout stays cancelled
`timescale 1ns/1ps
module rxc_top #(
  parameter logic [27:0] BOOT_TIMEOUT_CYCLES = rxc_pkg::BOOT_TIMEOUT_CY[27:0]
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // Register access
  input  wire rxc_pkg::rxc_req_t      req,
  output logic [7:0]                  rdata,
  // Device state
  input  wire logic                   full_shutdown_state,
  input  wire rxc_pkg::rxc_reg_stat_t reg1_stat,
  input  wire rxc_pkg::rxc_reg_stat_t reg2_stat,
  input  wire logic                   pull_up_wanted,
  // Controls
  output logic                        reg1_discharge,
  output logic                        reg1_scaling,
  output logic                        reg2_discharge,
  output logic                        reg2_scaling,
  output logic                        pin_pull_up,
  output logic                        pin_pull_down,
  output logic                        boot_shutdown
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  extra_ctrl;
    logic [7:0]  pwr_cfg;
    logic [27:0] timer;
    logic [7:0]  rdata;
    logic        pull_up;
    logic        pull_down;
    logic        shutdown;
  } rxc_state_t;

  rxc_state_t state;
  rxc_state_t next_state;

  // Values taken on reset
  localparam rxc_state_t RESET_STATE = '{
    extra_ctrl: rxc_pkg::RST_REGULATOR_EXTRA_CONTROL,
    pwr_cfg:    rxc_pkg::RST_POWER_CONFIGURATION,
    timer:      '0,
    rdata:      '0,
    pull_up:    1'b0,
    pull_down:  1'b0,
    shutdown:   1'b0
  };

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Write strobe aimed at one register address
  function automatic logic write_hit(
    input rxc_pkg::rxc_req_t r,
    input logic [7:0]        a
  );
    write_hit = r.wr && (r.addr == a);
  endfunction

  // Read value of one address; unmapped addresses read zero
  function automatic logic [7:0] read_reg(
    input logic [7:0] a,
    input rxc_state_t s
  );
    unique case (a)
      rxc_pkg::ADDR_REGULATOR_EXTRA_CONTROL: read_reg = s.extra_ctrl;
      rxc_pkg::ADDR_POWER_CONFIGURATION:     read_reg = s.pwr_cfg;
      default:                               read_reg = 8'h00;
    endcase
  endfunction

  // New power configuration image; the confirm bit only ever sets
  function automatic logic [7:0] pwr_cfg_write(
    input logic [7:0] wdata,
    input logic       confirmed
  );
    pwr_cfg_write = wdata & rxc_pkg::MASK_POWER_CONFIGURATION;
    pwr_cfg_write[rxc_pkg::BIT_BOOT_CONFIRM] =
      confirmed || wdata[rxc_pkg::BIT_BOOT_CONFIRM];
  endfunction

  // ****************************************************************
  // Strobes and flags
  // ****************************************************************
  logic wr_extra;
  logic wr_pwr;
  logic boot_ok;
  logic timeout_hit;
  logic pull_enable;

  assign wr_extra    = write_hit(req, rxc_pkg::ADDR_REGULATOR_EXTRA_CONTROL);
  assign wr_pwr      = write_hit(req, rxc_pkg::ADDR_POWER_CONFIGURATION);
  assign boot_ok     = state.pwr_cfg[rxc_pkg::BIT_BOOT_CONFIRM];
  // Last count before the timeout expires
  assign timeout_hit = (state.timer >= (BOOT_TIMEOUT_CYCLES - 28'h0000001));
  assign pull_enable = state.pwr_cfg[rxc_pkg::BIT_PIN_AUTO_PULL];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;

    // Register writes; reserved bits are dropped
    if (wr_extra) begin
      next_state.extra_ctrl = req.wdata & rxc_pkg::MASK_REGULATOR_EXTRA_CONTROL;
    end
    if (wr_pwr) begin
      next_state.pwr_cfg = pwr_cfg_write(req.wdata, boot_ok);
    end

    // Read data stands until the next read
    if (req.rd) begin
      next_state.rdata = read_reg(req.addr, state);
    end

    // Boot watchdog counts from power-on until confirmed or until the timeout sets shutdown
    if (!boot_ok && !state.shutdown) begin
      if (timeout_hit) begin
        next_state.shutdown = 1'b1;
      end else begin
        next_state.timer = state.timer + 28'h0000001;
      end
    end
    // Confirmed: the timeout stays cancelled
    if (boot_ok) begin
      next_state.timer = '0;
    end

    // Pulls only while automatic pulls are enabled
    next_state.pull_up   = pull_enable && pull_up_wanted;
    next_state.pull_down = pull_enable && !pull_up_wanted;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Shutdown stays set until the next reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata         = state.rdata;
  assign pin_pull_up   = state.pull_up;
  assign pin_pull_down = state.pull_down;
  assign boot_shutdown = state.shutdown;

  // ****************************************************************
  // Regulators
  // ****************************************************************
  // Each regulator gets its own instance of one control module
  localparam int NUM_REGS = 2;

  // Discharge select field of one regulator
  function automatic int discharge_bit(input int idx);
    if (idx == 0) begin
      discharge_bit = rxc_pkg::BIT_REG1_DISCHARGE_SEL;
    end else begin
      discharge_bit = rxc_pkg::BIT_REG2_DISCHARGE_SEL;
    end
  endfunction

  // Forced scaling field of one regulator
  function automatic int scaling_bit(input int idx);
    if (idx == 0) begin
      scaling_bit = rxc_pkg::BIT_REG1_FORCE_SCALING;
    end else begin
      scaling_bit = rxc_pkg::BIT_REG2_FORCE_SCALING;
    end
  endfunction

  rxc_pkg::rxc_reg_stat_t reg_stat      [NUM_REGS];
  logic [NUM_REGS-1:0]    reg_discharge;
  logic [NUM_REGS-1:0]    reg_scaling;

  assign reg_stat[0] = reg1_stat;
  assign reg_stat[1] = reg2_stat;

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    rxc_regulator_ctrl u_ctrl (
      .sys_clk             (sys_clk),
      .nrst                (nrst),
      .discharge_select    (state.extra_ctrl[discharge_bit(i)]),
      .force_scaling       (state.extra_ctrl[scaling_bit(i)]),
      .full_shutdown_state (full_shutdown_state),
      .stat                (reg_stat[i]),
      .ctrl_discharge      (reg_discharge[i]),
      .ctrl_scaling        (reg_scaling[i])
    );
  end

  // Index 0 is the first regulator, index 1 the second
  assign reg1_discharge = reg_discharge[0];
  assign reg1_scaling   = reg_scaling[0];
  assign reg2_discharge = reg_discharge[1];
  assign reg2_scaling   = reg_scaling[1];

endmodule

// ### pkg/rxc_pkg.sv
// Constants and carrier types for the regulator extra control block
// Assumes an upstream I2C target that presents decoded register accesses
package rxc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_REGULATOR_EXTRA_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_POWER_CONFIGURATION     = 8'h1d;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_REG1_FORCE_SCALING  = 0;
  localparam int BIT_REG1_DISCHARGE_SEL  = 1;
  localparam int BIT_REG2_FORCE_SCALING  = 4;
  localparam int BIT_REG2_DISCHARGE_SEL  = 5;
  localparam int BIT_BOOT_CONFIRM        = 0;
  localparam int BIT_PIN_AUTO_PULL       = 7;

  // Writable bit masks; all other bits read zero
  localparam logic [7:0] MASK_REGULATOR_EXTRA_CONTROL = 8'h33;
  localparam logic [7:0] MASK_POWER_CONFIGURATION     = 8'h81;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_REGULATOR_EXTRA_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_CONFIGURATION     = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ          = 25000000;
  localparam longint BOOT_TIMEOUT_S  = 5;
  localparam longint BOOT_TIMEOUT_CY = BOOT_TIMEOUT_S * CLK_HZ;
  localparam int     TIMER_W         = 28;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rxc_req_t;

  typedef struct packed {
    logic en;
    logic turn_on;
    logic steady_on;
  } rxc_reg_stat_t;

  typedef struct packed {
    logic discharge;
    logic force_scaling;
  } rxc_reg_ctrl_t;

endpackage
